// ---- nalu_pkg.sv ----
/*
 Package for the nibble ALU: widths, operation codes, status bit positions,
 decimal adjustment constants.
 Assumes a 4-bit data path and a 4-bit program status word.
*/
package nalu_pkg;
   // ------------------------------------------------------------------
   // Widths and positions
   // ------------------------------------------------------------------
   localparam int         NALU_W      = 4;
   localparam int         PSW_CARRY   = 1;
   localparam int         PSW_ZERO    = 2;
   localparam int         PSW_COMPARE = 3;
   localparam int         PSW_BCD     = 0;
   localparam logic [3:0] NALU_PSW_RST = 4'h0;
   localparam logic [3:0] NALU_ZERO    = 4'h0;
   localparam logic [3:0] NALU_TEN     = 4'ha;
   localparam logic [4:0] NALU_ADJ_ADD = 5'h06;
   localparam logic [4:0] NALU_ADJ_SUB = 5'h0a;
   localparam logic [4:0] NALU_DEC_MAX = 5'h09;
   localparam logic [4:0] NALU_SUM_MAX = 5'h13;

   // ------------------------------------------------------------------
   // Operations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      NALU_OP_ADD  = 2'b00,
      NALU_OP_ADDC = 2'b01,
      NALU_OP_SUB  = 2'b10,
      NALU_OP_SUBC = 2'b11
   } nalu_op_type;
endpackage : nalu_pkg

// ---- nalu_adjust.sv ----
/*
 Combinational nibble adder/subtractor with optional decimal adjustment.
 Assumes operands and carry-in are stable for the cycle they are used.
*/
`timescale 1ns/100ps
module nalu_adjust
   import nalu_pkg::*;
(
   input  wire logic [3:0] a,
   input  wire logic [3:0] b,
   input  wire logic       cin,
   input  wire logic       sub,
   input  wire logic       dec,
   output logic      [3:0] res,
   output logic            cout
);
   import nalu_pkg::*;

   // ------------------------------------------------------------------
   // Binary result, five bits
   // ------------------------------------------------------------------
   wire logic [4:0] add_raw = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   wire logic [4:0] sub_raw = {1'b0, a} - {1'b0, b} - {4'h0, cin};
   wire logic [4:0] raw     = sub ? sub_raw : add_raw;

   // ------------------------------------------------------------------
   // Decimal adjustment
   // ------------------------------------------------------------------
   // Correct only for sums 0..19; beyond that carry stays set and the
   // nibble lands at 1010B or above, which software can detect
   wire logic       add_over = raw > NALU_DEC_MAX;
   wire logic [4:0] add_adj  = raw + NALU_ADJ_ADD;
   // Sums 0..9 pass untouched; only a decimal carry takes the +6
   wire logic [3:0] add_fix  = add_over ? add_adj[3:0] : raw[3:0];
   wire logic [3:0] add_dec  = (raw > NALU_SUM_MAX) ?
                               (add_adj[3:0] | NALU_TEN) : add_fix;
   // Borrow gives ten's complement digit: -10 -> 0000B, -1 -> 1001B
   wire logic       sub_neg  = raw[4];
   wire logic [4:0] sub_adj  = raw + NALU_ADJ_SUB;
   wire logic       sub_bad  = !sub_neg && (raw > NALU_DEC_MAX);
   wire logic       neg_bad  = sub_neg && (raw[3:0] < 4'h6);
   // Differences 0..9 need no correction, only borrows do
   wire logic [3:0] sub_fix  = sub_neg ? sub_adj[3:0] : raw[3:0];
   wire logic [3:0] sub_dec  = (sub_bad || neg_bad) ?
                               (raw[3:0] | NALU_TEN) : sub_fix;

   assign res  = !dec ? raw[3:0] : (sub ? sub_dec : add_dec);
   assign cout = !dec ? raw[4] :
                 (sub ? (sub_neg || sub_bad) : add_over);
endmodule : nalu_adjust

// ---- nalu_core.sv ----
/*
 Nibble ALU with carry/zero flags, compare mode and decimal operations.
 Assumes the instruction sequencer gives one-cycle op_valid pulses with
 operands; the result write-back goes back to the sequencer.
*/
`timescale 1ns/100ps
module nalu_core
   import nalu_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        op_valid,
   input  wire nalu_op_type op_code,
   input  wire logic [3:0]  op_mem,
   input  wire logic [3:0]  op_src,
   input  wire logic        op_is_psw,
   input  wire logic        psw_wr,
   input  wire logic [3:0]  psw_wdata,
   output logic      [3:0]  program_status_word,
   output logic             carry_flag,
   output logic             zero_flag,
   output logic             compare_flag,
   output logic      [3:0]  result,
   output logic             result_wr
);
   import nalu_pkg::*;

   // ------------------------------------------------------------------
   // Operation decode
   // ------------------------------------------------------------------
   logic [3:0] psw_reg;
   logic [3:0] psw_next;
   logic [3:0] result_reg;
   logic       result_wr_reg;

   function automatic logic op_with_carry(input nalu_op_type op);
      op_with_carry = (op == NALU_OP_ADDC) || (op == NALU_OP_SUBC);
   endfunction : op_with_carry

   wire logic       is_sub  = (op_code == NALU_OP_SUB) ||
                              (op_code == NALU_OP_SUBC);
   wire logic       cin     = op_with_carry(op_code) & psw_reg[PSW_CARRY];
   wire logic       cmp_on  = psw_reg[PSW_COMPARE];
   wire logic [3:0] a_val   = op_is_psw ? psw_reg : op_mem;
   wire logic [3:0] alu_res;
   wire logic       alu_cy;

   nalu_adjust nalu_adjust_inst (
      .a    (a_val),
      .b    (op_src),
      .cin  (cin),
      .sub  (is_sub),
      .dec  (psw_reg[PSW_BCD]),
      .res  (alu_res),
      .cout (alu_cy)
   );

   // ------------------------------------------------------------------
   // Flag update
   // ------------------------------------------------------------------
   // Zero for chained ops holds only while the result stays zero
   wire logic z_hold  = op_with_carry(op_code) ? psw_reg[PSW_ZERO] : 1'b1;
   wire logic z_val   = (alu_res == NALU_ZERO) & z_hold;
   wire logic [3:0] flag_upd = {psw_reg[PSW_COMPARE], z_val, alu_cy,
                                psw_reg[PSW_BCD]};
   // Writing into the status word itself beats flags, unless comparing
   wire logic psw_dest = op_is_psw && !cmp_on;

   always_comb begin
      psw_next = psw_reg;
      if (psw_wr) begin
         psw_next = psw_wdata;
      end
      if (op_valid) begin
         psw_next = psw_dest ? alu_res : flag_upd;
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         psw_reg <= NALU_PSW_RST;
      end else begin
         psw_reg <= psw_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         result_reg    <= NALU_ZERO;
         result_wr_reg <= 1'b0;
      end else begin
         result_reg    <= alu_res;
         result_wr_reg <= op_valid && !cmp_on && !op_is_psw;
      end
   end

   assign program_status_word          = psw_reg;
   assign carry_flag   = psw_reg[PSW_CARRY];
   assign zero_flag    = psw_reg[PSW_ZERO];
   assign compare_flag = psw_reg[PSW_COMPARE];
   assign result       = result_reg;
   assign result_wr    = result_wr_reg;
endmodule : nalu_core

// ---- nalu_core_props.sv ----
/* Port checker for nalu_core.
   Assumes it is bound to the core from the test top. */
`timescale 1ns/100ps
module nalu_core_props
   import nalu_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        op_valid,
   input wire nalu_op_type op_code,
   input wire logic [3:0]  op_mem,
   input wire logic [3:0]  op_src,
   input wire logic        op_is_psw,
   input wire logic        psw_wr,
   input wire logic [3:0]  psw_wdata,
   input wire logic [3:0]  program_status_word,
   input wire logic        carry_flag,
   input wire logic        zero_flag,
   input wire logic        compare_flag,
   input wire logic [3:0]  result,
   input wire logic        result_wr
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_plain; op_valid && !op_is_psw; endsequence
   chk_wr_taken: assert property (
      s_plain ##0 !compare_flag |=> result_wr)
      else $error("write-back missing");
   chk_cmp_nowr: assert property (
      op_valid && compare_flag |=> !result_wr)
      else $error("write-back in compare mode");
   chk_zero_flag: assert property (
      s_plain ##0 !op_code[0] |=> zero_flag == (result == NALU_ZERO))
      else $error("zero flag wrong");
   chk_psw_hold: assert property (
      !op_valid && !psw_wr |=> $stable(program_status_word))
      else $error("status word moved");
   chk_psw_load: assert property (
      psw_wr && !op_valid |=> program_status_word == $past(psw_wdata))
      else $error("status word not loaded");
   chk_flag_alias: assert property (
      {compare_flag, zero_flag, carry_flag} == program_status_word[3:1])
      else $error("flag ports differ from status word");
   chk_hex_add: assert property (
      s_plain ##0 !program_status_word[PSW_BCD] && !compare_flag && op_code == NALU_OP_ADD
      |=> {carry_flag, result} == 5'($past(op_mem)) + 5'($past(op_src)))
      else $error("binary sum wrong");
   chk_dec_add: assert property (
      s_plain ##0 program_status_word[PSW_BCD] && op_code == NALU_OP_ADD
      && 5'(op_mem) + 5'(op_src) <= NALU_SUM_MAX
      |=> result <= NALU_DEC_MAX
      && 5'(carry_flag) * 5'(NALU_TEN) + 5'(result)
         == 5'($past(op_mem)) + 5'($past(op_src)))
      else $error("decimal sum wrong");
   chk_dec_over: assert property (
      s_plain ##0 program_status_word[PSW_BCD] && op_code == NALU_OP_ADD
      && 5'(op_mem) + 5'(op_src) > NALU_SUM_MAX
      |=> carry_flag && result >= NALU_TEN)
      else $error("decimal overflow not flagged");
endmodule : nalu_core_props

// ---- test_nalu_core.sv ----
/* Self-checking bench for nalu_core.
   Assumes the checker file is compiled first. */
`timescale 1ns/100ps
module test_nalu_core;
   import nalu_pkg::*;
   logic        clk_sys, resetn, op_valid, op_is_psw, psw_wr, carry_flag;
   logic        zero_flag, compare_flag, result_wr;
   logic [3:0]  op_mem, op_src, psw_wdata, program_status_word, result;
   nalu_op_type op_code;
   int          err_total, compares;
   nalu_core nalu_core_inst (.clk_sys, .resetn, .op_valid, .op_code, .op_mem,
      .op_src, .op_is_psw, .psw_wr, .psw_wdata, .program_status_word, .carry_flag, .zero_flag,
      .compare_flag, .result, .result_wr);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic report_and_stop;
      if (err_total == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [4:0] e, s);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic run(input nalu_op_type c, input logic [3:0] m, s, input p);
      // Idle edge first, so op_valid never rises in the step it fell
      @(posedge clk_sys);
      #1 op_valid = 1'h1;
      op_code = c;
      op_mem = m;
      op_src = s;
      op_is_psw = p;
      @(posedge clk_sys);
      #1 op_valid = 1'h0;
   endtask : run
   task automatic alu(input nalu_op_type c, input logic [3:0] m, s,
                      input logic [4:0] e);
      run(c, m, s, 1'h0);
      chk("carry_result", e, {carry_flag, result});
   endtask : alu
   task automatic ld(input logic [3:0] v);
      psw_wr = 1'h1;
      psw_wdata = v;
      @(posedge clk_sys);
      #1 psw_wr = 1'h0;
   endtask : ld
   task automatic t_hex;
      ld(4'h0);
      alu(NALU_OP_ADD, 4'h9, 4'h8, 5'h11);
      chk("result_wr", 5'h01, {4'h0, result_wr});
      alu(NALU_OP_SUB, 4'h5, 4'h5, 5'h00);
      chk("zero_flag", 5'h01, {4'h0, zero_flag});
      alu(NALU_OP_SUBC, 4'h3, 4'h4, 5'h1f);
      chk("zero_flag", 5'h00, {4'h0, zero_flag});
      alu(NALU_OP_ADDC, 4'h0, 4'h0, 5'h01);
   endtask : t_hex
   task automatic t_cmp;
      ld(4'h8);
      alu(NALU_OP_ADD, 4'hf, 4'h1, 5'h10);
      chk("result_wr", 5'h00, {4'h0, result_wr});
      chk("zero_flag", 5'h01, {4'h0, zero_flag});
      chk("compare_flag", 5'h01, {4'h0, compare_flag});
   endtask : t_cmp
   task automatic t_psw;
      ld(4'h0);
      run(NALU_OP_ADD, 4'h0, 4'h6, 1'h1);
      chk("psw", 5'h06, {1'b0, program_status_word});
      chk("result_wr", 5'h00, {4'h0, result_wr});
   endtask : t_psw
   task automatic t_dec;
      ld(4'h1);
      alu(NALU_OP_ADD, 4'h3, 4'h4, 5'h07);
      alu(NALU_OP_ADD, 4'h7, 4'h5, 5'h12);
      alu(NALU_OP_ADD, 4'h9, 4'ha, 5'h19);
      alu(NALU_OP_SUB, 4'h9, 4'h0, 5'h09);
      alu(NALU_OP_SUB, 4'h0, 4'ha, 5'h10);
      alu(NALU_OP_SUB, 4'h0, 4'h1, 5'h19);
      run(NALU_OP_ADD, 4'hf, 4'h5, 1'h0);
      chk("dec_over", 5'h03, {3'h0, carry_flag, result >= 4'ha});
      run(NALU_OP_SUB, 4'h0, 4'hf, 1'h0);
      chk("dec_under", 5'h03, {3'h0, carry_flag, result >= 4'ha});
   endtask : t_dec
   // ----------------------------------------
   // Clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      err_total++;
      report_and_stop;
   end
   initial begin
      {resetn, op_valid, op_is_psw, psw_wr, op_mem, op_src, psw_wdata} = '0;
      op_code = NALU_OP_ADD;
      repeat (8) @(posedge clk_sys);
      #1 resetn = 1'h1;
      chk("reset", 5'h00, {program_status_word, result_wr});
      t_hex;
      t_cmp;
      t_psw;
      t_dec;
      report_and_stop;
   end
endmodule : test_nalu_core
bind nalu_core nalu_core_props nalu_core_props_inst (.clk_sys, .resetn,
   .op_valid, .op_code, .op_mem, .op_src, .op_is_psw, .psw_wr, .psw_wdata,
   .program_status_word, .carry_flag, .zero_flag, .compare_flag, .result, .result_wr);
